// ---- core/pm_event_pkg.sv ----
// Constants for the power management event status and routing block.
// Assumes one event index per status bit, shared by all enable vectors.
package pm_event_pkg;
    localparam int NUM_EVENTS = 9;
    localparam int NUM_IRQ    = 16;

    // Event (status bit) positions
    localparam int EV_SMB_HOST   = 0;
    localparam int EV_SMB_SLAVE  = 1;
    localparam int EV_SMB_SNOOP  = 2;
    localparam int EV_SMB_ALERT  = 3;
    localparam int EV_HW_TRAP    = 4;
    localparam int EV_LPT_TRAP   = 5;
    localparam int EV_INACT      = 6;
    localparam int EV_USB_RESUME = 7;
    localparam int EV_BIOS_WE    = 8;

    // Which events own each kind of enable; other enable bits are ignored
    localparam logic [8:0] ACPI_CAPABLE  = 9'h0ff;
    localparam logic [8:0] SMI_CAPABLE   = 9'h1d1;
    localparam logic [8:0] C23_CAPABLE   = 9'h0ce;
    localparam logic [8:0] SLEEP_CAPABLE = 9'h086;

    // Group summary membership
    localparam logic [8:0] GRP_SMBUS   = 9'h00f;
    localparam logic [8:0] GRP_TRAP    = 9'h010;
    localparam logic [8:0] GRP_LPT_USB = 9'h0a0;
    localparam logic [8:0] GRP_MISC    = 9'h140;

    // Reset values
    localparam logic [8:0] STATUS_RST  = 9'h000;
endpackage : pm_event_pkg

// ---- core/pm_event_status_routing.sv ----
// Power management event latch, group summary and interrupt/resume routing.
// Assumes all inputs synchronous to sys_clk; enables held by software logic.
//
// What this block does
// - Each listed event sets its own software-readable status bit.
// - Group summary flags show whether any status in their group is set.
// - Status with ACPI enable raises ACPI interrupt, routed by select bit.
// - Separate SYS_MGMT_INTERRUPT-only enables send enabled status straight to SYS_MGMT_INTERRUPT.
// - IRQ lines, bus master, traps reload inactivity timer when enabled.
// - Enabled events resume from C2/C3 or from sleep states to full-on.
// - SMBus events share status; host event has SYS_MGMT_INTERRUPT; slave/snoop can resume.
// - Parallel port traps set status, reach ACPI interrupt, may reload timer.
// - Inactivity timeout sets status, ACPI or SYS_MGMT_INTERRUPT enable, C2/C3 resume.
// - USB resume in lpt/usb group, ACPI or SYS_MGMT_INTERRUPT, resumes from C2/C3/sleep.
// - BIOS write enable rising edge sets status, SYS_MGMT_INTERRUPT only, no ACPI path.
// - ACPI request is OR of status AND enable; SYS_MGMT_INTERRUPT path ignores select.
`timescale 1ns/10ps
module pm_event_status_routing #(
    parameter int N = pm_event_pkg::NUM_EVENTS,
    parameter int M = pm_event_pkg::NUM_IRQ
) (
    input  wire logic         sys_clk,
    input  wire logic         reset,
    input  wire logic [N-1:0] event_in,
    input  wire logic         bios_write_enable,
    input  wire logic [N-1:0] status_clear,
    input  wire logic [N-1:0] acpi_enable,
    input  wire logic [N-1:0] smi_enable,
    input  wire logic         acpi_irq_route_select,
    input  wire logic [N-1:0] resume_c23_enable,
    input  wire logic [N-1:0] resume_sleep_enable,
    input  wire logic [M-1:0] irq_line,
    input  wire logic [M-1:0] irq_reload_enable,
    input  wire logic         bus_master_active,
    input  wire logic         bus_master_reload_enable,
    input  wire logic         hw_trap_hit,
    input  wire logic         hw_trap_reload_enable,
    input  wire logic         lpt_trap_hit,
    input  wire logic         lpt_trap_reload_enable,
    output logic [N-1:0]      status_q,
    output logic              smbus_group_flag,
    output logic              trap_group_flag,
    output logic              lpt_usb_group_flag,
    output logic              misc_group_flag,
    output logic              acpi_control_interrupt,
    output logic              sys_mgmt_interrupt,
    output logic              inactivity_reload,
    output logic              resume_from_c23,
    output logic              resume_from_sleep
);

    ////////////////////////////////////////////////////////////////////////
    // Event capture

    logic         bios_we_q;
    logic [N-1:0] event_all;
    logic [N-1:0] status_d;

    // BIOS write enable only counts on its rising edge
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            bios_we_q <= 1'b0;
        end else begin
            bios_we_q <= bios_write_enable;
        end
    end

    always_comb begin
        event_all = event_in;
        event_all[pm_event_pkg::EV_BIOS_WE] = bios_write_enable & ~bios_we_q;
        event_all[pm_event_pkg::EV_HW_TRAP] = event_in[pm_event_pkg::EV_HW_TRAP] | hw_trap_hit;
        event_all[pm_event_pkg::EV_LPT_TRAP] = event_in[pm_event_pkg::EV_LPT_TRAP]
                                             | lpt_trap_hit;
    end

    // Set beats clear so an event landing on a clear is kept
    assign status_d = (status_q & ~status_clear) | event_all;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            status_q <= pm_event_pkg::STATUS_RST;
        end else begin
            status_q <= status_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Group summaries

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            smbus_group_flag   <= 1'b0;
            trap_group_flag    <= 1'b0;
            lpt_usb_group_flag <= 1'b0;
            misc_group_flag    <= 1'b0;
        end else begin
            smbus_group_flag   <= |(status_q & pm_event_pkg::GRP_SMBUS);
            trap_group_flag    <= |(status_q & pm_event_pkg::GRP_TRAP);
            lpt_usb_group_flag <= |(status_q & pm_event_pkg::GRP_LPT_USB);
            misc_group_flag    <= |(status_q & pm_event_pkg::GRP_MISC);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt routing

    logic acpi_any;
    logic smi_direct;

    // Capability masks stop an enable from opening a path the event lacks
    assign acpi_any   = |(status_q & acpi_enable & pm_event_pkg::ACPI_CAPABLE);
    assign smi_direct = |(status_q & smi_enable & pm_event_pkg::SMI_CAPABLE);

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            acpi_control_interrupt <= 1'b0;
            sys_mgmt_interrupt     <= 1'b0;
        end else begin
            acpi_control_interrupt <= acpi_any & acpi_irq_route_select;
            sys_mgmt_interrupt     <= (acpi_any & ~acpi_irq_route_select)
                                    | smi_direct;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Inactivity timer reload

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            inactivity_reload <= 1'b0;
        end else begin
            inactivity_reload <= (|(irq_line & irq_reload_enable))
                               | (bus_master_active & bus_master_reload_enable)
                               | (hw_trap_hit & hw_trap_reload_enable)
                               | (lpt_trap_hit & lpt_trap_reload_enable);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Resume requests to the power state machine

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            resume_from_c23   <= 1'b0;
            resume_from_sleep <= 1'b0;
        end else begin
            resume_from_c23   <= |(status_q & resume_c23_enable
                                   & pm_event_pkg::C23_CAPABLE);
            resume_from_sleep <= |(status_q & resume_sleep_enable
                                   & pm_event_pkg::SLEEP_CAPABLE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence bios_we_rise;
        !bios_write_enable ##1 bios_write_enable;
    endsequence

    // Events seen while held in reset are dropped, so skip the first edge after it
    AST_STATUS_SETS: assert property (
        !$past(reset) |-> ((status_q & $past(event_all)) == $past(event_all)))
        else $error("Event did not set its status bit");

    AST_STATUS_HOLDS: assert property (
        ((status_q & $past(status_q & ~status_clear)) == $past(status_q & ~status_clear)))
        else $error("Status bit dropped without a clear");

    AST_CLEAR_WORKS: assert property (
        (status_q[0] && status_clear[0] && !event_all[0]) |=> !status_q[0])
        else $error("Status bit did not clear");

    AST_GROUP_SMBUS: assert property (
        (|status_q[3:0]) |=> smbus_group_flag)
        else $error("SMBus group flag missing");

    AST_GROUP_LPT_USB: assert property (
        (|(status_q & pm_event_pkg::GRP_LPT_USB)) |=> lpt_usb_group_flag)
        else $error("LPT/USB group flag missing");

    AST_GROUP_IDLE: assert property (
        (status_q == '0)
        |=> !(smbus_group_flag || trap_group_flag || lpt_usb_group_flag || misc_group_flag))
        else $error("Group flag set with no status");

    AST_SCI_ROUTE: assert property (
        (acpi_any && acpi_irq_route_select)
        |=> (acpi_control_interrupt && (sys_mgmt_interrupt == $past(smi_direct))))
        else $error("ACPI interrupt not raised as ACPI_CONTROL_INTERRUPT");

    AST_SMI_ROUTE: assert property (
        (acpi_any && !acpi_irq_route_select) |=> (sys_mgmt_interrupt && !acpi_control_interrupt))
        else $error("ACPI interrupt not raised as SYS_MGMT_INTERRUPT");

    AST_SMI_DIRECT: assert property (
        (status_q[pm_event_pkg::EV_INACT] && smi_enable[pm_event_pkg::EV_INACT])
        |=> sys_mgmt_interrupt)
        else $error("Direct SYS_MGMT_INTERRUPT missing");

    AST_BIOS_WE: assert property (
        bios_we_rise |=> status_q[pm_event_pkg::EV_BIOS_WE])
        else $error("BIOS write enable edge not latched");

    AST_BIOS_NO_ACPI: assert property (
        (status_q == 9'h100) |=> !acpi_control_interrupt)
        else $error("BIOS write enable reached ACPI interrupt");

    AST_RELOAD: assert property (
        (bus_master_active && bus_master_reload_enable) |=> inactivity_reload)
        else $error("Inactivity timer reload missing");

    AST_LPT_RELOAD: assert property (
        (lpt_trap_hit && lpt_trap_reload_enable) |=> inactivity_reload)
        else $error("Parallel port trap did not reload the timer");

    AST_RESUME_SLEEP: assert property (
        (status_q[pm_event_pkg::EV_USB_RESUME] && resume_sleep_enable[pm_event_pkg::EV_USB_RESUME])
        |=> resume_from_sleep)
        else $error("Sleep resume missing");

    AST_RESUME_C23: assert property (
        (status_q[pm_event_pkg::EV_INACT] && resume_c23_enable[pm_event_pkg::EV_INACT])
        |=> resume_from_c23)
        else $error("C2/C3 resume missing");

endmodule : pm_event_status_routing

// ---- verif/tb.sv ----
// Self-checking bench for the event status and routing block.
// Assumes the block's outputs are registered; flags, interrupts and resumes lag status by one cycle.
`timescale 1ns/10ps
module tb;
    localparam int N = pm_event_pkg::NUM_EVENTS;
    localparam int M = pm_event_pkg::NUM_IRQ;
    logic         sys_clk, reset, bios_write_enable, acpi_irq_route_select;
    logic [N-1:0] event_in, status_clear, acpi_enable, smi_enable;
    logic [N-1:0] resume_c23_enable, resume_sleep_enable, status_q;
    logic [M-1:0] irq_line, irq_reload_enable;
    logic         bus_master_active, bus_master_reload_enable, hw_trap_hit;
    logic         hw_trap_reload_enable, lpt_trap_hit, lpt_trap_reload_enable;
    logic         smbus_group_flag, trap_group_flag, lpt_usb_group_flag, misc_group_flag;
    logic         acpi_control_interrupt, sys_mgmt_interrupt, inactivity_reload;
    logic         resume_from_c23, resume_from_sleep;
    logic [N-1:0] m_status;
    logic         m_bios;
    int           num_errors, check_count, timer;

    pm_event_status_routing #(
        .N(N),
        .M(M)
    ) DUT (
        .sys_clk                 (sys_clk),
        .reset                   (reset),
        .event_in                (event_in),
        .bios_write_enable       (bios_write_enable),
        .status_clear            (status_clear),
        .acpi_enable             (acpi_enable),
        .smi_enable              (smi_enable),
        .acpi_irq_route_select   (acpi_irq_route_select),
        .resume_c23_enable       (resume_c23_enable),
        .resume_sleep_enable     (resume_sleep_enable),
        .irq_line                (irq_line),
        .irq_reload_enable       (irq_reload_enable),
        .bus_master_active       (bus_master_active),
        .bus_master_reload_enable(bus_master_reload_enable),
        .hw_trap_hit             (hw_trap_hit),
        .hw_trap_reload_enable   (hw_trap_reload_enable),
        .lpt_trap_hit            (lpt_trap_hit),
        .lpt_trap_reload_enable  (lpt_trap_reload_enable),
        .status_q                (status_q),
        .smbus_group_flag        (smbus_group_flag),
        .trap_group_flag         (trap_group_flag),
        .lpt_usb_group_flag      (lpt_usb_group_flag),
        .misc_group_flag         (misc_group_flag),
        .acpi_control_interrupt  (acpi_control_interrupt),
        .sys_mgmt_interrupt      (sys_mgmt_interrupt),
        .inactivity_reload       (inactivity_reload),
        .resume_from_c23         (resume_from_c23),
        .resume_from_sleep       (resume_from_sleep)
    );

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // Hang guard: the whole run needs 1605 cycles, well under the 5000 limit
    always @(posedge sys_clk) begin
        timer++;
        if (timer > 5000) begin
            num_errors++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [N-1:0] exp, input logic [N-1:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    function automatic logic [7:0] outs(input logic [N-1:0] s);
        logic a, m;
        a = |(s & acpi_enable & pm_event_pkg::ACPI_CAPABLE);
        m = |(s & smi_enable & pm_event_pkg::SMI_CAPABLE);
        return {|(s & pm_event_pkg::GRP_SMBUS), |(s & pm_event_pkg::GRP_TRAP),
                |(s & pm_event_pkg::GRP_LPT_USB), |(s & pm_event_pkg::GRP_MISC),
                a & acpi_irq_route_select, m | (a & ~acpi_irq_route_select),
                |(s & resume_c23_enable & pm_event_pkg::C23_CAPABLE),
                |(s & resume_sleep_enable & pm_event_pkg::SLEEP_CAPABLE)};
    endfunction : outs

    // Model runs on the inputs held over the coming edge
    task automatic step();
        logic [N-1:0] ev, nxt;
        logic [7:0]   eo;
        logic [3:0]   grp;
        logic         er;
        ev = event_in & 9'h0ff;
        ev[8] = bios_write_enable & ~m_bios;
        ev[4] = ev[4] | hw_trap_hit;
        ev[5] = ev[5] | lpt_trap_hit;
        nxt = (m_status & ~status_clear) | ev;
        eo = outs(m_status);
        er = |(irq_line & irq_reload_enable) | (bus_master_active & bus_master_reload_enable)
             | (hw_trap_hit & hw_trap_reload_enable) | (lpt_trap_hit & lpt_trap_reload_enable);
        if (reset) begin
            nxt = '0;
            eo = '0;
            er = 1'b0;
        end
        @(posedge sys_clk);
        #1;
        grp = {smbus_group_flag, trap_group_flag, lpt_usb_group_flag, misc_group_flag};
        check("status_q", nxt, status_q);
        check("group flags", N'(eo[7:4]), N'(grp));
        check("interrupts", N'(eo[3:2]), N'({acpi_control_interrupt, sys_mgmt_interrupt}));
        check("reload", N'(er), N'(inactivity_reload));
        check("resume", N'(eo[1:0]), N'({resume_from_c23, resume_from_sleep}));
        m_status = nxt;
        m_bios = reset ? 1'b0 : bios_write_enable;
    endtask : step

    task automatic drive_random();
        event_in = ($urandom % 4 == 0) ? N'(1) << ($urandom % N) : '0;
        status_clear = ($urandom % 3 == 0) ? N'($urandom) : '0;
        {acpi_enable, smi_enable} = 18'($urandom);
        {resume_c23_enable, resume_sleep_enable} = 18'($urandom);
        {irq_line, irq_reload_enable} = $urandom;
        {bus_master_active, bus_master_reload_enable, hw_trap_hit, hw_trap_reload_enable,
         lpt_trap_hit, lpt_trap_reload_enable, acpi_irq_route_select} = 7'($urandom);
        if ($urandom % 5 == 0) bios_write_enable = ~bios_write_enable;
    endtask : drive_random

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(78854));
        reset = 1'b1;
        m_status = '0;
        m_bios = 1'b0;
        {event_in, status_clear, acpi_enable, smi_enable} = '0;
        {resume_c23_enable, resume_sleep_enable, irq_line, irq_reload_enable} = '0;
        {bios_write_enable, acpi_irq_route_select, bus_master_active} = '0;
        {bus_master_reload_enable, hw_trap_hit, hw_trap_reload_enable} = '0;
        {lpt_trap_hit, lpt_trap_reload_enable} = '0;
        repeat (2) step();
        reset = 1'b0;
        repeat (1500) begin
            drive_random();
            step();
        end
        $display("test random traffic done");
        // Each event alone: sticky after it ends, set beats clear for all but BIOS write enable, whose event_in bit is ignored
        for (int i = 0; i < N; i++) begin
            {event_in, hw_trap_hit, lpt_trap_hit, bios_write_enable} = '0;
            {acpi_enable, smi_enable, resume_c23_enable, resume_sleep_enable} = '1;
            acpi_irq_route_select = i[0];
            status_clear = '1;
            repeat (2) step();
            status_clear = '0;
            if (i == 4) hw_trap_hit = 1'b1;
            else if (i == 5) lpt_trap_hit = 1'b1;
            else if (i == 8) bios_write_enable = 1'b1;
            else event_in[i] = 1'b1;
            step();
            {event_in, hw_trap_hit, lpt_trap_hit} = '0;
            repeat (3) step();
            status_clear = '1;
            event_in = N'(1) << i;
            step();
            event_in = '0;
            repeat (2) step();
        end
        $display("test single events done");
        // Reset in mid-run with enables live and status already cleared
        reset = 1'b1;
        repeat (2) step();
        reset = 1'b0;
        repeat (20) begin
            drive_random();
            step();
        end
        $display("test mid-run reset done");
        give_verdict();
    end
endmodule : tb
